// [logic/fuse_prog_pkg.sv]
package fuse_prog_pkg;
    localparam int CLK_MHZ          = 25;
    // pulse width limits in nanoseconds
    localparam int ZERO_MIN_NS      = 50;
    localparam int ZERO_MAX_NS      = 10_000;
    localparam int ONE_MIN_NS       = 50_000;
    // a pulse of t ns is seen floor(t/period) samples or one more, so the
    // zero maximum gets one extra cycle to keep a legal pulse legal at every sampling phase
    localparam int ZERO_MIN_CYC     = (ZERO_MIN_NS * CLK_MHZ) / 1000;
    localparam int ZERO_MAX_CYC     = (ZERO_MAX_NS * CLK_MHZ) / 1000 + 1;
    localparam int ONE_MIN_CYC      = (ONE_MIN_NS * CLK_MHZ) / 1000;
    localparam int WIDTH_CNT_BITS   = 11;

    localparam int WORD_BITS        = 38;
    localparam int READ_BITS        = 8;
    // positions inside the shift register; first bit sent ends up at the top
    localparam int START_MSB        = 37;
    localparam int START_LSB        = 26;
    localparam int FUNC_MSB         = 25;
    localparam int FUNC_LSB         = 24;
    localparam int PARAM_MSB        = 23;
    localparam int PARAM_LSB        = 22;
    localparam int DUMMY_MSB        = 21;
    localparam int DUMMY_LSB        = 20;
    localparam int VALUE_MSB        = 19;
    localparam int VALUE_LSB        = 12;
    localparam int END_MSB          = 11;
    localparam int END_LSB          = 0;

    localparam logic [11:0] START_MARK = 12'h0801;
    localparam logic [11:0] END_MARK   = 12'h07FE;
    localparam logic [1:0]  DUMMY_MARK = 2'h2;

    localparam int LOCK_BIT         = 0;
    localparam int TEST_BIT         = 1;
    localparam int CHECK_BIT        = 2;

    localparam logic [2:0] GAIN2_RESET  = 3'h0;
    localparam logic [6:0] GAIN1_RESET  = 7'h00;
    localparam logic [7:0] OFFSET_RESET = 8'h00;

    typedef enum logic [1:0] {
        FN_SENSE    = 2'h0,
        FN_SIMULATE = 2'h1,
        FN_PROGRAM  = 2'h2,
        FN_READ     = 2'h3
    } func_t;

    typedef enum logic [1:0] {
        PAR_GAIN2  = 2'h0,
        PAR_GAIN1  = 2'h1,
        PAR_OFFSET = 2'h2,
        PAR_OTHER  = 2'h3
    } param_t;
endpackage : fuse_prog_pkg

// [logic/pulse_bit_if.sv]
`timescale 1ns/1ps
interface pulse_bit_if;
    logic strobe;
    logic value;
    modport meter (output strobe, output value);
    modport sink  (input strobe, input value);
endinterface : pulse_bit_if

// [logic/pulse_width_meter.sv]
`timescale 1ns/1ps
module pulse_width_meter
    import fuse_prog_pkg::*;
#(
    parameter int CNT_BITS = WIDTH_CNT_BITS
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pulse_level,
    pulse_bit_if.meter bits
);
    localparam logic [CNT_BITS-1:0] Z_MIN = CNT_BITS'(ZERO_MIN_CYC);
    localparam logic [CNT_BITS-1:0] Z_MAX = CNT_BITS'(ZERO_MAX_CYC);
    localparam logic [CNT_BITS-1:0] O_MIN = CNT_BITS'(ONE_MIN_CYC);

    logic [CNT_BITS-1:0] width;
    logic                prev_level;
    logic                falling;
    logic                is_zero;
    logic                is_one;

    assign falling = prev_level & ~pulse_level;
    assign is_zero = (width >= Z_MIN) && (width <= Z_MAX);
    assign is_one  = (width >= O_MIN);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_level <= 1'b0;
        end else begin
            prev_level <= pulse_level;
        end
    end

    // saturate at the one threshold so very long pulses still count as ones
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            width <= '0;
        end else if (pulse_level) begin
            if (width < O_MIN) begin
                width <= width + CNT_BITS'(1);
            end
        end else begin
            width <= '0;
        end
    end

    // widths between the two ranges are dropped rather than guessed
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bits.strobe <= 1'b0;
            bits.value  <= 1'b0;
        end else begin
            bits.strobe <= falling && (is_zero || is_one);
            bits.value  <= is_one;
        end
    end
endmodule : pulse_width_meter

// [logic/fuse_programmer.sv]
`timescale 1ns/1ps
module fuse_programmer
    import fuse_prog_pkg::*;
(
    input  wire logic       SYS_CLK,
    input  wire logic       RST,
    input  wire logic       SERIAL_PULSE_INPUT,
    input  wire logic [2:0] GAIN2_FUSE,
    input  wire logic [6:0] GAIN1_FUSE,
    input  wire logic [7:0] OFFSET_FUSE,
    input  wire logic       LOCK_FUSE_STATE,
    input  wire logic       TEST_FUSE_STATE,
    input  wire logic       CHECK_FUSE_STATE,
    output logic            SERIAL_PULL_DOWN_EN,
    output logic [2:0]      BLOW_GAIN2,
    output logic [6:0]      BLOW_GAIN1,
    output logic [7:0]      BLOW_OFFSET,
    output logic [2:0]      BLOW_OTHER,
    output logic            LOW_SENSE_CURRENT,
    output logic [2:0]      GAIN2_CODE,
    output logic [6:0]      GAIN1_CODE,
    output logic [7:0]      OFFSET_CODE,
    output logic            PARITY_FAULT,
    output logic            AMPLIFIER_OUTPUT_LOW,
    output logic            READBACK_ENABLE,
    output logic            READBACK_OUTPUT_PIN
);
    localparam int FUSE_BITS = 21;

    logic [1:0]           pulse_sync;
    logic [FUSE_BITS-1:0] fuse_meta;
    logic [FUSE_BITS-1:0] fuse_sync;
    logic [2:0]           g2_fuse;
    logic [6:0]           g1_fuse;
    logic [7:0]           off_fuse;
    logic                 lock_fuse;
    logic                 test_fuse;
    logic                 check_fuse;

    logic [WORD_BITS-1:0] word;
    logic                 fresh;
    logic                 framed;
    logic                 matched;
    func_t                func;
    param_t               param;
    logic [7:0]           value;

    logic [2:0]           sim_g2;
    logic [6:0]           sim_g1;
    logic [7:0]           sim_off;
    logic [READ_BITS-1:0] rb_shift;
    logic [3:0]           rb_count;
    logic                 rb_active;
    logic [READ_BITS-1:0] next_rb_load;

    logic [2:0]           act_g2;
    logic [6:0]           act_g1;
    logic [7:0]           act_off;

    pulse_bit_if bit_link ();

    // the pin pull-down is an analog sink; enabling it permanently keeps a floating pin low
    assign SERIAL_PULL_DOWN_EN = 1'b1;

    // two flip-flops before anything looks at the pin or the fuse sense lines
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pulse_sync <= 2'h0;
        end else begin
            pulse_sync <= {pulse_sync[0], SERIAL_PULSE_INPUT};
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            fuse_meta <= '0;
            fuse_sync <= '0;
        end else begin
            fuse_meta <= {CHECK_FUSE_STATE, TEST_FUSE_STATE, LOCK_FUSE_STATE, OFFSET_FUSE, GAIN1_FUSE, GAIN2_FUSE};
            fuse_sync <= fuse_meta;
        end
    end

    assign g2_fuse    = fuse_sync[2:0];
    assign g1_fuse    = fuse_sync[9:3];
    assign off_fuse   = fuse_sync[17:10];
    assign lock_fuse  = fuse_sync[18];
    assign test_fuse  = fuse_sync[19];
    assign check_fuse = fuse_sync[20];

    pulse_width_meter #(
        .CNT_BITS (WIDTH_CNT_BITS)
    ) u_meter (
        .clk         (SYS_CLK),
        .rst         (RST),
        .pulse_level (pulse_sync[1]),
        .bits        (bit_link.meter)
    );

    // bits arrive msb first, so shifting in at the bottom leaves field 0 at the top
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            word <= '0;
        end else if (bit_link.strobe) begin
            word <= {word[WORD_BITS-2:0], bit_link.value};
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            fresh <= 1'b0;
        end else begin
            fresh <= bit_link.strobe;
        end
    end

    assign framed  = (word[START_MSB:START_LSB] == START_MARK) && (word[END_MSB:END_LSB] == END_MARK);
    assign matched = framed && (word[DUMMY_MSB:DUMMY_LSB] == DUMMY_MARK);
    assign func    = func_t'(word[FUNC_MSB:FUNC_LSB]);
    assign param   = param_t'(word[PARAM_MSB:PARAM_LSB]);
    assign value   = word[VALUE_MSB:VALUE_LSB];

    // switches follow the word level, so they drop the moment the next bit breaks the frame;
    // the lock fuse ends programming for good
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            BLOW_GAIN2  <= 3'h0;
            BLOW_GAIN1  <= 7'h00;
            BLOW_OFFSET <= 8'h00;
            BLOW_OTHER  <= 3'h0;
        end else begin
            BLOW_GAIN2  <= 3'h0;
            BLOW_GAIN1  <= 7'h00;
            BLOW_OFFSET <= 8'h00;
            BLOW_OTHER  <= 3'h0;
            if (matched && func == FN_PROGRAM && !lock_fuse) begin
                unique case (param)
                    PAR_GAIN2:  BLOW_GAIN2  <= value[2:0];
                    PAR_GAIN1:  BLOW_GAIN1  <= value[6:0];
                    PAR_OFFSET: BLOW_OFFSET <= value;
                    PAR_OTHER:  BLOW_OTHER  <= {value[CHECK_BIT], value[TEST_BIT], value[LOCK_BIT]};
                endcase
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sim_g2  <= GAIN2_RESET;
            sim_g1  <= GAIN1_RESET;
            sim_off <= OFFSET_RESET;
        end else if (lock_fuse) begin
            sim_g2  <= GAIN2_RESET;
            sim_g1  <= GAIN1_RESET;
            sim_off <= OFFSET_RESET;
        end else if (fresh && framed && func == FN_SIMULATE) begin
            unique case (param)
                PAR_GAIN2:  sim_g2  <= value[2:0];
                PAR_GAIN1:  sim_g1  <= value[6:0];
                PAR_OFFSET: sim_off <= value;
                PAR_OTHER:  sim_g2  <= sim_g2;
            endcase
        end
    end

    // low sense current is requested with value bit 0 set; normal code clears it
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            LOW_SENSE_CURRENT <= 1'b0;
        end else if (fresh && framed && func == FN_SENSE) begin
            LOW_SENSE_CURRENT <= value[0];
        end
    end

    always_comb begin
        next_rb_load = '0;
        unique case (param)
            PAR_GAIN2:  next_rb_load = {5'h00, g2_fuse};
            PAR_GAIN1:  next_rb_load = {1'b0, g1_fuse};
            PAR_OFFSET: next_rb_load = off_fuse;
            PAR_OTHER:  next_rb_load = {5'h00, check_fuse, test_fuse, lock_fuse};
        endcase
    end

    // the pulse that completes a read word is not counted; counting starts with the next
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rb_shift  <= '0;
            rb_count  <= 4'h0;
            rb_active <= 1'b0;
        end else if (fresh && framed && func == FN_READ) begin
            rb_shift  <= next_rb_load;
            rb_count  <= 4'h0;
            rb_active <= 1'b1;
        end else if (rb_active && bit_link.strobe) begin
            rb_shift  <= {rb_shift[READ_BITS-2:0], 1'b0};
            rb_count  <= rb_count + 4'h1;
            if (rb_count == 4'(READ_BITS - 1)) begin
                rb_active <= 1'b0;
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            READBACK_ENABLE     <= 1'b0;
            READBACK_OUTPUT_PIN <= 1'b0;
        end else begin
            READBACK_ENABLE     <= rb_active;
            READBACK_OUTPUT_PIN <= rb_active & rb_shift[READ_BITS-1];
        end
    end

    assign act_g2  = lock_fuse ? g2_fuse  : sim_g2;
    assign act_g1  = lock_fuse ? g1_fuse  : sim_g1;
    assign act_off = lock_fuse ? off_fuse : sim_off;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            GAIN2_CODE           <= GAIN2_RESET;
            GAIN1_CODE           <= GAIN1_RESET;
            OFFSET_CODE          <= OFFSET_RESET;
            PARITY_FAULT         <= 1'b0;
            AMPLIFIER_OUTPUT_LOW <= 1'b0;
        end else begin
            GAIN2_CODE           <= act_g2;
            GAIN1_CODE           <= act_g1;
            OFFSET_CODE          <= act_off;
            PARITY_FAULT         <= lock_fuse & (^{act_g2, act_g1, act_off, check_fuse});
            AMPLIFIER_OUTPUT_LOW <= lock_fuse & (^{act_g2, act_g1, act_off, check_fuse});
        end
    end
endmodule : fuse_programmer

// [tb/fuse_programmer_asserts.sv]
`timescale 1ns/1ps
module fuse_programmer_asserts (
    input wire logic       SYS_CLK,
    input wire logic       RST,
    input wire logic       SERIAL_PULSE_INPUT,
    input wire logic [2:0] GAIN2_FUSE,
    input wire logic [6:0] GAIN1_FUSE,
    input wire logic [7:0] OFFSET_FUSE,
    input wire logic       LOCK_FUSE_STATE,
    input wire logic       CHECK_FUSE_STATE,
    input wire logic       SERIAL_PULL_DOWN_EN,
    input wire logic [2:0] BLOW_GAIN2,
    input wire logic [6:0] BLOW_GAIN1,
    input wire logic [7:0] BLOW_OFFSET,
    input wire logic [2:0] BLOW_OTHER,
    input wire logic [2:0] GAIN2_CODE,
    input wire logic [6:0] GAIN1_CODE,
    input wire logic [7:0] OFFSET_CODE,
    input wire logic       PARITY_FAULT,
    input wire logic       AMPLIFIER_OUTPUT_LOW,
    input wire logic       READBACK_ENABLE,
    input wire logic       READBACK_OUTPUT_PIN
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    logic [20:0] blows;
    assign blows = {BLOW_GAIN2, BLOW_GAIN1, BLOW_OFFSET, BLOW_OTHER};

    // six cycles cover the two-stage fuse synchroniser plus the code register
    sequence s_locked_steady;
        (LOCK_FUSE_STATE && $stable({GAIN2_FUSE, GAIN1_FUSE, OFFSET_FUSE, CHECK_FUSE_STATE}))[*6];
    endsequence
    sequence s_open_quiet;
        (!LOCK_FUSE_STATE)[*5];
    endsequence
    // a bit only lands after a fall, so a long high stretch freezes the decode
    sequence s_pin_held;
        (SERIAL_PULSE_INPUT && !LOCK_FUSE_STATE)[*8];
    endsequence

    chk_pulldown_on: assert property (SERIAL_PULL_DOWN_EN == 1'b1)
        else $error("pull-down enable dropped");
    chk_fault_gated: assert property (s_open_quiet |-> !PARITY_FAULT)
        else $error("parity fault while lock fuse intact");
    chk_fault_drives_out: assert property (AMPLIFIER_OUTPUT_LOW == PARITY_FAULT)
        else $error("output low differs from parity fault");
    chk_locked_codes: assert property (s_locked_steady |->
        {GAIN2_CODE, GAIN1_CODE, OFFSET_CODE} == {GAIN2_FUSE, GAIN1_FUSE, OFFSET_FUSE})
        else $error("locked codes differ from fuses");
    chk_parity_value: assert property (s_locked_steady |->
        PARITY_FAULT == ^{GAIN2_FUSE, GAIN1_FUSE, OFFSET_FUSE, CHECK_FUSE_STATE})
        else $error("parity fault value wrong");
    chk_locked_no_blow: assert property (s_locked_steady |-> blows == 21'h0)
        else $error("blow switch on after lock");
    chk_blow_after_fall: assert property ($rose(|blows) |-> !$past(SERIAL_PULSE_INPUT, 2))
        else $error("blow switch rose without a completed bit");
    chk_pin_high_hold: assert property (s_pin_held |->
        $stable({GAIN2_CODE, GAIN1_CODE, OFFSET_CODE, READBACK_ENABLE, blows}))
        else $error("state changed while pulse still high");
    chk_readback_quiet: assert property (!READBACK_ENABLE |-> !READBACK_OUTPUT_PIN)
        else $error("readback pin high outside read mode");
endmodule : fuse_programmer_asserts

bind fuse_programmer fuse_programmer_asserts fuse_programmer_asserts_i (
    .SYS_CLK(SYS_CLK), .RST(RST), .SERIAL_PULSE_INPUT(SERIAL_PULSE_INPUT),
    .GAIN2_FUSE(GAIN2_FUSE), .GAIN1_FUSE(GAIN1_FUSE), .OFFSET_FUSE(OFFSET_FUSE),
    .LOCK_FUSE_STATE(LOCK_FUSE_STATE), .CHECK_FUSE_STATE(CHECK_FUSE_STATE),
    .SERIAL_PULL_DOWN_EN(SERIAL_PULL_DOWN_EN), .BLOW_GAIN2(BLOW_GAIN2), .BLOW_GAIN1(BLOW_GAIN1),
    .BLOW_OFFSET(BLOW_OFFSET), .BLOW_OTHER(BLOW_OTHER), .GAIN2_CODE(GAIN2_CODE),
    .GAIN1_CODE(GAIN1_CODE), .OFFSET_CODE(OFFSET_CODE), .PARITY_FAULT(PARITY_FAULT),
    .AMPLIFIER_OUTPUT_LOW(AMPLIFIER_OUTPUT_LOW), .READBACK_ENABLE(READBACK_ENABLE),
    .READBACK_OUTPUT_PIN(READBACK_OUTPUT_PIN));

// [tb/fuse_pulse_source.sv]
`timescale 1ns/1ps
module fuse_pulse_source (
    input  wire logic clk,
    output logic      pin
);
    initial pin = 1'b0;

    task automatic pulse(input int cyc);
        @(posedge clk);
        pin <= 1'b1;
        repeat (cyc) @(posedge clk);
        pin <= 1'b0;
        repeat (250) @(posedge clk);
    endtask : pulse

    // one is sent at exactly the shortest legal width to probe the boundary
    task automatic send_bit(input logic b);
        pulse(b ? 1250 : 10);
    endtask : send_bit

    task automatic send_word(input logic [37:0] w);
        for (int i = 37; i >= 0; i--) begin
            send_bit(w[i]);
        end
    endtask : send_word
endmodule : fuse_pulse_source

// [tb/tb_fuse_programmer.sv]
`timescale 1ns/1ps
module tb_fuse_programmer
    import fuse_prog_pkg::*;
;
    typedef struct {int sel; logic [7:0] exp;} note_t;
    logic       clk = 1'b0, rst = 1'b1, lock_f = 1'b0, test_f = 1'b0, check_f = 1'b0;
    logic [2:0] g2f = 3'h0, blow_g2, blow_oth, g2_code;
    logic [6:0] g1f = 7'h00, blow_g1, g1_code;
    logic [7:0] off_f = 8'h00, blow_off, off_code, v, g;
    logic       pin, pd_en, low_sense, parity, out_low, rb_en, rb_pin;
    note_t      notes[$];
    event       check_ev;
    int         fail_count = 0;
    int         total_checks = 0;

    always #20 clk = ~clk;

    fuse_pulse_source fuse_pulse_source_i (.clk(clk), .pin(pin));
    fuse_programmer fuse_programmer_i (
        .SYS_CLK(clk), .RST(rst), .SERIAL_PULSE_INPUT(pin), .GAIN2_FUSE(g2f), .GAIN1_FUSE(g1f),
        .OFFSET_FUSE(off_f), .LOCK_FUSE_STATE(lock_f), .TEST_FUSE_STATE(test_f),
        .CHECK_FUSE_STATE(check_f), .SERIAL_PULL_DOWN_EN(pd_en), .BLOW_GAIN2(blow_g2),
        .BLOW_GAIN1(blow_g1), .BLOW_OFFSET(blow_off), .BLOW_OTHER(blow_oth),
        .LOW_SENSE_CURRENT(low_sense), .GAIN2_CODE(g2_code), .GAIN1_CODE(g1_code),
        .OFFSET_CODE(off_code), .PARITY_FAULT(parity), .AMPLIFIER_OUTPUT_LOW(out_low),
        .READBACK_ENABLE(rb_en), .READBACK_OUTPUT_PIN(rb_pin));

    function automatic logic [37:0] mk(input logic [1:0] f, input logic [1:0] p, input logic [7:0] val);
        return {START_MARK, f, p, DUMMY_MARK, val, END_MARK};
    endfunction : mk

    function automatic logic [7:0] pick(input int s);
        case (s)
            0:       return {5'h0, g2_code};
            1:       return {1'h0, g1_code};
            2:       return off_code;
            3:       return {5'h0, blow_g2};
            4:       return {7'h0, rb_pin};
            5:       return {7'h0, rb_en};
            6:       return {7'h0, parity};
            8:       return {1'h0, blow_g1};
            9:       return blow_off;
            10:      return {5'h0, blow_oth};
            11:      return {7'h0, out_low};
            12:      return {7'h0, pd_en};
            default: return {7'h0, low_sense};
        endcase
    endfunction : pick

    task automatic expect_val(input int s, input logic [7:0] e);
        notes.push_back('{s, e});
        -> check_ev;
    endtask : expect_val

    // outputs settle well inside ten cycles after the last pin fall
    task automatic settle();
        repeat (10) @(posedge clk);
        #5;
    endtask : settle

    always @(check_ev) begin : monitor
        note_t n;
        while (notes.size() > 0) begin
            n = notes.pop_front();
            total_checks++;
            if (pick(n.sel) !== n.exp) begin
                fail_count++;
                $display("[ERR] %0t sel %0d got %h exp %h", $time, n.sel, pick(n.sel), n.exp);
            end
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (200000) @(posedge clk);
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report();
    end

    initial begin
        void'($urandom(40305));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        settle();
        for (int s = 0; s < 12; s++) begin
            expect_val(s, 8'h00);
        end
        expect_val(12, 8'h01);
        $display("test reset done");
        v = 8'($urandom);
        fuse_pulse_source_i.send_word(mk(FN_SIMULATE, PAR_GAIN2, v));
        settle();
        expect_val(0, {5'h0, v[2:0]});
        expect_val(1, 8'h00);
        $display("test simulate done");
        fuse_pulse_source_i.send_word(mk(FN_SENSE, PAR_GAIN2, 8'h01));
        settle();
        expect_val(7, 8'h01);
        expect_val(0, {5'h0, v[2:0]});
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        settle();
        expect_val(7, 8'h00);
        expect_val(0, 8'h00);
        $display("test sense and reset done");
        v = 8'h01 << $urandom_range(2, 0);
        fuse_pulse_source_i.send_word(mk(FN_PROGRAM, PAR_GAIN2, v));
        settle();
        expect_val(3, v);
        expect_val(8, 8'h00);
        expect_val(9, 8'h00);
        expect_val(10, 8'h00);
        repeat (25000) @(posedge clk);
        fuse_pulse_source_i.send_bit(1'b0);
        settle();
        expect_val(3, 8'h00);
        $display("test program done");
        @(posedge clk);
        g2f <= 3'($urandom);
        fuse_pulse_source_i.send_word(mk(FN_READ, PAR_GAIN2, 8'h00));
        g = {5'h0, g2f};
        settle();
        expect_val(5, 8'h01);
        expect_val(4, {7'h0, g[7]});
        for (int k = 1; k <= 8; k++) begin
            fuse_pulse_source_i.send_bit(1'b0);
            settle();
            if (k < 8) expect_val(4, {7'h0, g[7 - k]});
            else expect_val(5, 8'h00);
        end
        $display("test read done");
        @(posedge clk);
        {g2f, g1f, off_f, check_f} <= 19'($urandom);
        lock_f <= 1'b1;
        settle();
        expect_val(0, {5'h0, g2f});
        expect_val(1, {1'h0, g1f});
        expect_val(2, off_f);
        expect_val(6, {7'h0, ^{g2f, g1f, off_f, check_f}});
        expect_val(11, {7'h0, ^{g2f, g1f, off_f, check_f}});
        $display("test lock done");
        // let the monitor drain the last notes before the run ends
        @(posedge clk);
        final_report();
    end
endmodule : tb_fuse_programmer
